//--- pou_pkg.sv
/*
 * Constants, register indices and carrier types of the pattern output unit.
 * Assumes a single 40 MHz clock domain and word-addressed Avalon-MM access.
 */
package pou_pkg;

    // ********************************************************
    // Register indices (Avalon word address, byte address = 4 x index)
    // ********************************************************
    localparam logic [15:0] POU_IDX_NEXT_HIGH_UPPER = 16'hffa4;
    localparam logic [15:0] POU_IDX_NEXT_LOW_UPPER = 16'hffa5;
    localparam logic [15:0] POU_IDX_NEXT_HIGH_LOWER = 16'hffa6;
    localparam logic [15:0] POU_IDX_NEXT_LOW_LOWER = 16'hffa7;
    localparam logic [15:0] POU_IDX_TRIGGER_SELECT = 16'hffb0;
    localparam logic [15:0] POU_IDX_ENABLE_LOW = 16'hffb1;
    localparam logic [15:0] POU_IDX_ENABLE_HIGH = 16'hffb2;

    // ********************************************************
    // Field positions and values after reset
    // ********************************************************
    localparam int POU_GROUPS = 4;
    localparam int POU_GROUP_BITS = 4;
    localparam int POU_SEL_BITS = 2;
    localparam logic [7:0] POU_NEXT_RESET = 8'h00;
    localparam logic [7:0] POU_ENABLE_RESET = 8'h00;
    localparam logic [7:0] POU_TRIGGER_RESET = 8'hff;
    localparam logic [7:0] POU_LATCH_RESET = 8'h00;
    localparam logic [3:0] POU_RESERVED_NIBBLE = 4'hf;
    localparam logic [7:0] POU_RESERVED_BYTE = 8'hff;
    localparam logic [2:0] POU_SYNC_RESET = 3'h7;

    // ********************************************************
    // Carrier types
    // ********************************************************
    typedef struct packed {
        logic [7:0] trigger_select_reg;
        logic [7:0] output_enable_high;
        logic [7:0] output_enable_low;
        logic [7:0] next_data_high;
        logic [7:0] next_data_low;
    } pou_regs_s;

    typedef struct packed {
        pou_regs_s regs;
        logic [7:0] port_a_output_latch;
        logic [7:0] port_b_output_latch;
        logic [2:0] standby_sync;
        logic standby_active;
        logic waitrequest;
        logic [31:0] readdata;
    } pou_state_s;

endpackage : pou_pkg

//--- pou_group_xfer.sv
/*
 * One nibble group of pattern output: picks its compare-match strobe and
 * merges enabled next-data bits over the current latch value.
 * Assumes the strobes are one-cycle pulses on the block's own clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pou_group_xfer
    import pou_pkg::*;
(
    // Trigger
    input wire logic [1:0] sel,
    input wire logic [3:0] strobe,
    // Data
    input wire logic [3:0] enable_bits,
    input wire logic [3:0] next_bits,
    input wire logic [3:0] current,
    // Result
    output logic [3:0] updated
);

    logic fired;

    always_comb begin
        fired = strobe[sel];                                     // R14
        updated = current;
        if (fired) begin
            updated = (next_bits & enable_bits) | (current & ~enable_bits); // R04
        end
    end

endmodule : pou_group_xfer

`default_nettype wire

//--- pou_reg_view.sv
/*
 * Read view of the register file, including the split next-data layout.
 * Assumes the caller registers the result before it reaches the bus.
 */
`timescale 1ns/1ps
`default_nettype none

module pou_reg_view
    import pou_pkg::*;
(
    // Register contents
    input wire pou_regs_s regs,
    // Lookup
    input wire logic [15:0] index,
    output logic [7:0] rdata,
    output logic hit
);

    logic same_high;
    logic same_low;

    always_comb begin
        same_high = regs.trigger_select_reg[7:6] == regs.trigger_select_reg[5:4];
        same_low = regs.trigger_select_reg[3:2] == regs.trigger_select_reg[1:0];
        rdata = 8'h00;
        hit = 1'b1;
        case (index)
            POU_IDX_NEXT_HIGH_UPPER: begin
                if (same_high) begin
                    rdata = regs.next_data_high;
                end else begin
                    rdata = {regs.next_data_high[7:4], POU_RESERVED_NIBBLE}; // R01
                end
            end
            POU_IDX_NEXT_HIGH_LOWER: begin
                if (same_high) begin
                    rdata = POU_RESERVED_BYTE;                       // R13
                end else begin
                    rdata = {POU_RESERVED_NIBBLE, regs.next_data_high[3:0]}; // R02
                end
            end
            POU_IDX_NEXT_LOW_UPPER: begin
                if (same_low) begin
                    rdata = regs.next_data_low;                      // R15
                end else begin
                    rdata = {regs.next_data_low[7:4], POU_RESERVED_NIBBLE}; // R15
                end
            end
            POU_IDX_NEXT_LOW_LOWER: begin
                if (same_low) begin
                    rdata = POU_RESERVED_BYTE;                       // R13
                end else begin
                    rdata = {POU_RESERVED_NIBBLE, regs.next_data_low[3:0]}; // R15
                end
            end
            POU_IDX_TRIGGER_SELECT: rdata = regs.trigger_select_reg;
            POU_IDX_ENABLE_LOW: rdata = regs.output_enable_low;      // R03
            POU_IDX_ENABLE_HIGH: rdata = regs.output_enable_high;    // R08
            default: begin
                hit = 1'b0;
            end
        endcase
    end

endmodule : pou_reg_view

`default_nettype wire

//--- pou_pattern_output_unit.sv
/*
 * Pattern output unit: next-data registers, per-bit enables, trigger select
 * and the two port output latches, reached over an Avalon-MM slave.
 * Assumes timer compare-match strobes come from logic on the same clock and
 * that the hardware standby pin is asynchronous and active low.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// R01: With different triggers for groups 2 and 3, the upper high address holds group 3 data in bits 7 to 4 and reads one in bits 3 to 0.
// R02: With different triggers, the lower high address holds group 2 data in bits 3 to 0 and bits 7 to 4 are fixed ones.
// R03: The low enable register is eight read/write bits, one per output bit 7 to 0.
// R04: An enabled low bit copies its next-data bit into the port A latch on the selected compare match.
// R05: A disabled low bit is not copied, so its port A bit keeps its value.
// R06: Next-data bits 7 to 0 map one to one onto port A bits 7 to 0, each gated by the same enable bit.
// R07: The low enable register clears to zero on reset and on entering hardware standby.
// R08: The high enable register is eight read/write bits, one per output bit 15 to 8.
// R09: An enabled high bit copies its next-data bit into the port B latch on the selected compare match.
// R10: A disabled high bit is not copied, so its port B bit stays unchanged.
// R11: Next-data bits 15 to 8 map in order onto port B bits 7 to 0, each gated by the matching enable bit.
// R12: The high enable register clears on reset and hardware standby, and both enables keep their value in software standby.
// R13: Reserved bits of the split layout ignore writes and read as one.
// R14: Each group has a two-bit trigger field choosing timer channel 0 to 3, resetting to channel 3.
// R15: Groups 0 and 1 share one byte address under a common trigger and split over two addresses otherwise.
// R16: Enabled transfers happen on the clock edge of the selected strobe, for all bits of the group at once.
module pou_pattern_output_unit
    import pou_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Hardware standby pin, active low
    input wire logic hw_standby_n,
    // Timer unit compare-match strobes, channels 3 to 0
    input wire logic [3:0] compare_match,
    // Avalon-MM slave
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Port output latches driving the pattern pins
    output logic [7:0] port_a_output_latch,
    output logic [7:0] port_b_output_latch
);

    // ********************************************************
    // State
    // ********************************************************
    pou_state_s s;
    pou_state_s next_s;

    logic [7:0] view_rdata;
    logic view_hit;
    logic [15:0] latch_now;
    logic [15:0] latch_after;
    logic [15:0] enables_all;
    logic [15:0] next_all;

    // ********************************************************
    // Read view
    // ********************************************************
    pou_reg_view u_view (
        .regs(s.regs),
        .index(address),
        .rdata(view_rdata),
        .hit(view_hit)
    );

    // ********************************************************
    // Pattern transfer, one instance per nibble group
    // ********************************************************
    assign latch_now = {s.port_b_output_latch, s.port_a_output_latch};
    assign enables_all = {s.regs.output_enable_high, s.regs.output_enable_low};
    assign next_all = {s.regs.next_data_high, s.regs.next_data_low};

    genvar g;
    generate
        for (g = 0; g < POU_GROUPS; g++) begin : gen_group
            pou_group_xfer u_xfer (
                .sel(s.regs.trigger_select_reg[g*POU_SEL_BITS +: POU_SEL_BITS]),
                .strobe(compare_match),
                .enable_bits(enables_all[g*POU_GROUP_BITS +: POU_GROUP_BITS]),
                .next_bits(next_all[g*POU_GROUP_BITS +: POU_GROUP_BITS]),
                .current(latch_now[g*POU_GROUP_BITS +: POU_GROUP_BITS]),
                .updated(latch_after[g*POU_GROUP_BITS +: POU_GROUP_BITS])
            );
        end
    endgenerate

    // ********************************************************
    // Next state
    // ********************************************************
    logic same_high;
    logic same_low;
    logic bus_req;
    logic do_write;
    logic lane0;

    always_comb begin
        next_s = s;
        same_high = s.regs.trigger_select_reg[7:6] == s.regs.trigger_select_reg[5:4];
        same_low = s.regs.trigger_select_reg[3:2] == s.regs.trigger_select_reg[1:0];
        bus_req = read | write;
        do_write = write & ~s.waitrequest;
        lane0 = byteenable[0];

        // Standby pin: the first stage feeds only the second
        next_s.standby_sync = {s.standby_sync[1:0], hw_standby_n};
        if (s.standby_sync[1] == s.standby_sync[2]) begin
            next_s.standby_active = ~s.standby_sync[2];
        end

        // One wait state, then a single cycle with waitrequest low
        next_s.waitrequest = ~(bus_req & s.waitrequest);
        if (read & s.waitrequest) begin
            next_s.readdata = view_hit ? {24'h000000, view_rdata} : 32'h00000000;
        end

        // Latches update on the strobe edge for all enabled bits
        next_s.port_a_output_latch = latch_after[7:0];           // R06 R05 R16
        next_s.port_b_output_latch = latch_after[15:8];          // R11 R09 R10 R16

        if (do_write & lane0) begin
            case (address)
                POU_IDX_NEXT_HIGH_UPPER: begin
                    next_s.regs.next_data_high[7:4] = writedata[7:4]; // R01
                    if (same_high) begin
                        next_s.regs.next_data_high[3:0] = writedata[3:0];
                    end
                end
                POU_IDX_NEXT_HIGH_LOWER: begin
                    if (!same_high) begin
                        next_s.regs.next_data_high[3:0] = writedata[3:0]; // R02 R13
                    end
                end
                POU_IDX_NEXT_LOW_UPPER: begin
                    next_s.regs.next_data_low[7:4] = writedata[7:4]; // R15
                    if (same_low) begin
                        next_s.regs.next_data_low[3:0] = writedata[3:0];
                    end
                end
                POU_IDX_NEXT_LOW_LOWER: begin
                    if (!same_low) begin
                        next_s.regs.next_data_low[3:0] = writedata[3:0]; // R15 R13
                    end
                end
                POU_IDX_TRIGGER_SELECT: begin
                    next_s.regs.trigger_select_reg = writedata[7:0]; // R14
                end
                POU_IDX_ENABLE_LOW: begin
                    next_s.regs.output_enable_low = writedata[7:0]; // R03
                end
                POU_IDX_ENABLE_HIGH: begin
                    next_s.regs.output_enable_high = writedata[7:0]; // R08
                end
                default: begin
                end
            endcase
        end

        // Hardware standby returns registers and latches to their reset values
        if (s.standby_active) begin
            next_s.regs.next_data_low = POU_NEXT_RESET;
            next_s.regs.next_data_high = POU_NEXT_RESET;
            next_s.regs.output_enable_low = POU_ENABLE_RESET;    // R07
            next_s.regs.output_enable_high = POU_ENABLE_RESET;   // R12
            next_s.regs.trigger_select_reg = POU_TRIGGER_RESET;  // R14
            next_s.port_a_output_latch = POU_LATCH_RESET;
            next_s.port_b_output_latch = POU_LATCH_RESET;
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s.regs.next_data_low <= POU_NEXT_RESET;
            s.regs.next_data_high <= POU_NEXT_RESET;
            s.regs.output_enable_low <= POU_ENABLE_RESET;        // R07
            s.regs.output_enable_high <= POU_ENABLE_RESET;       // R12
            s.regs.trigger_select_reg <= POU_TRIGGER_RESET;      // R14
            s.port_a_output_latch <= POU_LATCH_RESET;
            s.port_b_output_latch <= POU_LATCH_RESET;
            s.standby_sync <= POU_SYNC_RESET;
            s.standby_active <= 1'b0;
            s.waitrequest <= 1'b1;
            s.readdata <= 32'h00000000;
        end else begin
            s <= next_s;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign readdata = s.readdata;
    assign waitrequest = s.waitrequest;
    assign port_a_output_latch = s.port_a_output_latch;
    assign port_b_output_latch = s.port_b_output_latch;

endmodule : pou_pattern_output_unit

`default_nettype wire

//--- pou_pattern_output_unit_checker.sv
/*
 * Concurrent checks on the ports of the pattern output unit.
 * Assumes one clock domain and the bind below at every top instance.
 */
`timescale 1ns/1ps
`default_nettype none

module pou_pattern_output_unit_checker (
    // Clock, reset and standby
    input wire logic clock,
    input wire logic rst,
    input wire logic hw_standby_n,
    // Strobes and bus
    input wire logic [3:0] compare_match,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Output latches
    input wire logic [7:0] port_a_output_latch,
    input wire logic [7:0] port_b_output_latch
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_one_wait_state: assert property (((read || write) && waitrequest) |=> !waitrequest)
        else $error("bus answer not in the cycle after the request");
    a_wait_low_once: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait_high: assert property (!(read || write) |=> waitrequest)
        else $error("waitrequest low without a request");
    a_upper_bits_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_readdata_holds: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("read data changed without a read");
    a_port_a_hold: assert property (disable iff (rst || !hw_standby_n)
        compare_match == 4'h0 |=> $stable(port_a_output_latch))
        else $error("port A latch changed without a strobe");
    a_port_b_hold: assert property (disable iff (rst || !hw_standby_n)
        compare_match == 4'h0 |=> $stable(port_b_output_latch))
        else $error("port B latch changed without a strobe");
    a_reset_state: assert property (disable iff (1'b0)
        $fell(rst) |-> (port_a_output_latch == 8'h00 && port_b_output_latch == 8'h00
        && waitrequest))
        else $error("outputs not in reset state after reset");
endmodule : pou_pattern_output_unit_checker

bind pou_pattern_output_unit pou_pattern_output_unit_checker u_pou_pattern_output_unit_checker (
    .clock(clock), .rst(rst), .hw_standby_n(hw_standby_n), .compare_match(compare_match),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .port_a_output_latch(port_a_output_latch), .port_b_output_latch(port_b_output_latch)
);

`default_nettype wire

//--- pou_timer_model.sv
/*
 * Timer unit stand-in: turns a request into one-cycle compare-match pulses.
 * Assumes the request is held for exactly one cycle by the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module pou_timer_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request
    input wire logic start,
    input wire logic [3:0] chan,
    // Strobes
    output logic [3:0] compare_match
);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            compare_match <= 4'h0;
        end else begin
            compare_match <= start ? chan : 4'h0;
        end
    end
endmodule : pou_timer_model

`default_nettype wire

//--- pou_pattern_output_unit_tb.sv
/*
 * Self-checking bench: Avalon register tasks, timer strobes, standby.
 * Assumes the checker is bound through its own file.
 */
`timescale 1ns/1ps
`default_nettype none

module pou_pattern_output_unit_tb;
    import pou_pkg::*;
    logic clock, rst, hw_standby_n, read, write, waitrequest, start;
    logic [3:0] compare_match, byteenable, chan;
    logic [15:0] address;
    logic [31:0] writedata, readdata;
    logic [7:0] port_a_output_latch, port_b_output_latch;
    logic [7:0] ea [4] = '{8'h24, 8'h24, 8'ha4, 8'ha6};
    logic [7:0] eb [4] = '{8'h52, 8'h59, 8'h59, 8'h59};
    int fail_count = 0;
    int tests_run = 0;

    pou_pattern_output_unit u_pou_pattern_output_unit (.clock(clock), .rst(rst),
        .hw_standby_n(hw_standby_n), .compare_match(compare_match), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .port_a_output_latch(port_a_output_latch), .port_b_output_latch(port_b_output_latch));
    pou_timer_model u_pou_timer_model (.clock(clock), .rst(rst), .start(start), .chan(chan),
        .compare_match(compare_match));

    always #12.5 clock = ~clock;

    // ********************************************************
    // Tasks
    // ********************************************************
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
             output logic [7:0] rv);
        int n;
        n = 0;
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= idx;
        writedata <= {24'h000000, wd};
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            check(8'h00, 8'h01);
        end
        rv = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] v;
        bus(1'b1, idx, d, v);
    endtask : wr

    task rd(input logic [15:0] idx, input logic [7:0] e);
        logic [7:0] v;
        bus(1'b0, idx, 8'h00, v);
        check(v, e);
    endtask : rd

    task pulse(input logic [3:0] m);
        @(posedge clock);
        start <= 1'b1;
        chan <= m;
        @(posedge clock);
        start <= 1'b0;
        @(posedge clock);
        @(negedge clock);
    endtask : pulse

    task test_done;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // ********************************************************
    // Tests
    // ********************************************************
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        test_done;
    end

    initial begin
        clock = 0; rst = 1; hw_standby_n = 1; start = 0; chan = 4'h0; address = 16'h0000;
        read = 0; write = 0; writedata = 32'h0; byteenable = 4'h1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(POU_IDX_ENABLE_LOW, 8'h00);
        rd(POU_IDX_ENABLE_HIGH, 8'h00);
        rd(POU_IDX_TRIGGER_SELECT, 8'hff);
        rd(POU_IDX_NEXT_HIGH_LOWER, 8'hff);
        rd(16'h0123, 8'h00);
        $display("test reset values done");
        wr(POU_IDX_ENABLE_LOW, 8'ha5);
        wr(POU_IDX_ENABLE_HIGH, 8'h5a);
        rd(POU_IDX_ENABLE_LOW, 8'ha5);
        rd(POU_IDX_ENABLE_HIGH, 8'h5a);
        wr(POU_IDX_NEXT_LOW_UPPER, 8'h3c);
        wr(POU_IDX_NEXT_HIGH_UPPER, 8'hc3);
        wr(POU_IDX_NEXT_HIGH_LOWER, 8'h00);
        rd(POU_IDX_NEXT_HIGH_UPPER, 8'hc3);
        pulse(4'h8);
        check(port_a_output_latch, 8'h24);
        check(port_b_output_latch, 8'h42);
        $display("test enabled transfer done");
        wr(POU_IDX_TRIGGER_SELECT, 8'h1b);
        rd(POU_IDX_NEXT_HIGH_UPPER, 8'hcf);
        rd(POU_IDX_NEXT_HIGH_LOWER, 8'hf3);
        wr(POU_IDX_NEXT_HIGH_UPPER, 8'h50);
        wr(POU_IDX_NEXT_HIGH_LOWER, 8'h09);
        rd(POU_IDX_NEXT_HIGH_UPPER, 8'h5f);
        rd(POU_IDX_NEXT_HIGH_LOWER, 8'hf9);
        wr(POU_IDX_NEXT_LOW_UPPER, 8'ha0);
        wr(POU_IDX_NEXT_LOW_LOWER, 8'h06);
        rd(POU_IDX_NEXT_LOW_UPPER, 8'haf);
        rd(POU_IDX_NEXT_LOW_LOWER, 8'hf6);
        wr(POU_IDX_ENABLE_LOW, 8'hff);
        wr(POU_IDX_ENABLE_HIGH, 8'hff);
        for (int ch = 0; ch < 4; ch++) begin
            pulse(4'h1 << ch);
            check(port_a_output_latch, ea[ch]);
            check(port_b_output_latch, eb[ch]);
        end
        $display("test split triggers done");
        @(posedge clock);
        hw_standby_n <= 1'b0;
        repeat (8) @(posedge clock);
        hw_standby_n <= 1'b1;
        repeat (8) @(posedge clock);
        rd(POU_IDX_ENABLE_LOW, 8'h00);
        rd(POU_IDX_ENABLE_HIGH, 8'h00);
        rd(POU_IDX_TRIGGER_SELECT, 8'hff);
        check(port_a_output_latch, 8'h00);
        check(port_b_output_latch, 8'h00);
        rd(POU_IDX_NEXT_LOW_UPPER, 8'h00);
        byteenable <= 4'h0;
        wr(POU_IDX_ENABLE_LOW, 8'h3c);
        byteenable <= 4'h1;
        rd(POU_IDX_ENABLE_LOW, 8'h00);
        $display("test hardware standby done");
        test_done;
    end
endmodule : pou_pattern_output_unit_tb

`default_nettype wire
